// *** rtl/rocof_stage.sv ***
/*
 * frequency slope protection stage: qualification, pick-up, definite
 * or inverse trip timing, release, setting groups, counters, fault
 * record, events and interrupt, with a plain register port.
 * assumes measurement inputs synchronous to clk, slope in 0.01 Hz/s.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - frequency taken from first two voltage inputs, one must be live
// R2 - start qualifies after slope above pick-up continuously for 80 ms
// R3 - stage picks up and asserts start 60 ms after qualification
// R4 - trip at delay end only if average slope since pick-up exceeds setting
// R5 - while picked up, keep averaging; fluctuations do not release
// R6 - release and drop start after about 80 ms of stable frequency
// R7 - software sets minimum delay equal to delay for definite time
// R8 - minimum delay below delay gives inverse time pickup*delay/avg slope
// R9 - never trip sooner than the minimum delay
// R10 - pick-up below 0.7 Hz/s adds a floor on fastest trip time
// R11 - four setting groups chosen by digital, virtual or manual input
// R12 - cumulative start and trip counters readable
// R13 - record maximum slope and elapsed delay percent, trip is 100
// R14 - four events, each enableable, enabled after reset
// R15 - measured frequency and slope readable continuously
module rocof_stage #(
	parameter int TICK_CYCLES = rocof_pkg::TICK_CYCLES,
	parameter int NUM_W = 40
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// measurement front end
	input  wire logic [15:0] freqA,
	input  wire logic [15:0] freqB,
	input  wire logic        voltOkA,
	input  wire logic        voltOkB,
	input  wire logic [15:0] slopeIn,
	// setting group selection
	input  wire logic [1:0]  groupDi,
	input  wire logic [1:0]  groupVi,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	// stage outputs
	output logic             startOut,
	output logic             tripOut,
	output logic             startRiseEvt,
	output logic             startFallEvt,
	output logic             tripRiseEvt,
	output logic             tripFallEvt,
	output logic             irq
);

	typedef enum {ST_IDLE, ST_QUAL, ST_DELAY, ST_PICKED, ST_TRIPPED}
		rocof_state_t;

	function automatic logic [15:0] absVal(input logic [15:0] v);
		absVal = v[15] ? 16'(-v) : v;
	endfunction

	function automatic logic [31:0] mul16(input logic [15:0] a,
		input logic [15:0] b);
		mul16 = 32'(a) * 32'(b);
	endfunction

	// ----------------------------------------------------------------
	// millisecond tick and measurement
	// ----------------------------------------------------------------
	logic        tick;
	logic [15:0] freqVal;
	logic [15:0] slopeVal;
	logic [15:0] absSlope;
	logic        freqOk;

	rocof_tick_gen #(.CYCLES(TICK_CYCLES)) uTick (
		.clk  (clk),
		.nrst (nrst),
		.tick (tick)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			freqVal <= 16'h0000;
			slopeVal <= 16'h0000;
			absSlope <= 16'h0000;
			freqOk <= 1'b0;
		end else begin
			freqOk <= voltOkA | voltOkB; // R1
			if (voltOkA)
				freqVal <= freqA; // R1
			else if (voltOkB)
				freqVal <= freqB; // R1
			slopeVal <= slopeIn; // R15
			absSlope <= (voltOkA | voltOkB) ? absVal(slopeIn) : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// control and setting groups
	// ----------------------------------------------------------------
	logic [15:0] pickup [rocof_pkg::NGRP];
	logic [15:0] opDelay [rocof_pkg::NGRP];
	logic [15:0] minimumDelay [rocof_pkg::NGRP];
	logic [1:0]  manualGrp;
	logic [1:0]  grpSrc;
	logic [3:0]  evtEn;
	logic [1:0]  activeGrp;
	logic        grpHit;
	logic        ctrlWr;

	assign grpHit = wr && addr[7:6] == rocof_pkg::GRP_SPACE;
	assign ctrlWr = wr && addr == rocof_pkg::OFS_CTRL;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < rocof_pkg::NGRP; i++) begin
				pickup[i] <= rocof_pkg::PICKUP_RST;
				opDelay[i] <= rocof_pkg::OP_DELAY_RST;
				minimumDelay[i] <= rocof_pkg::MIN_DELAY_RST;
			end
		end else if (grpHit) begin
			case (addr[3:2])
				rocof_pkg::GF_PICKUP: pickup[addr[5:4]] <= wdata[15:0];
				rocof_pkg::GF_OP_DELAY: opDelay[addr[5:4]] <= wdata[15:0];
				rocof_pkg::GF_MIN_DELAY:
					minimumDelay[addr[5:4]] <= wdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			manualGrp <= 2'h0;
			grpSrc <= 2'h0;
			evtEn <= rocof_pkg::EVT_EN_RST;
		end else if (ctrlWr) begin
			manualGrp <= wdata[rocof_pkg::CTRL_GRP_LSB +: 2];
			grpSrc <= wdata[rocof_pkg::CTRL_SRC_LSB +: 2];
			evtEn <= wdata[rocof_pkg::CTRL_EVT_LSB +: 4]; // R14
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			activeGrp <= 2'h0;
		else
			case (grpSrc)
				rocof_pkg::ROCOF_SRC_DIGITAL: activeGrp <= groupDi; // R11
				rocof_pkg::ROCOF_SRC_VIRTUAL: activeGrp <= groupVi; // R11
				default: activeGrp <= manualGrp; // R11
			endcase
	end

	// ----------------------------------------------------------------
	// trip timing
	// ----------------------------------------------------------------
	logic [15:0]  curPick;
	logic [15:0]  curDelay;
	logic [15:0]  floorMs;
	logic [31:0]  target;
	logic         above;
	rocof_state_t state;
	rocof_state_t next_state;
	logic [15:0]  phaseCnt;
	logic [15:0]  stableCnt;
	logic [15:0]  elapsed;
	logic [31:0]  sum;
	logic [15:0]  maxSlope;
	logic [15:0]  nextElapsed;
	logic [31:0]  nextSum;
	logic         tripNow;
	logic         releaseNow;

	assign curPick = pickup[activeGrp];
	assign curDelay = opDelay[activeGrp];
	assign target = mul16(curPick, curDelay); // R8
	assign above = absSlope > curPick;
	assign nextElapsed = elapsed + 16'h0001;
	assign nextSum = sum + 32'(absSlope); // R5

	always_comb begin
		floorMs = minimumDelay[activeGrp]; // R9
		if (curPick < rocof_pkg::LOW_SLOPE_LIMIT
			&& floorMs < 16'(rocof_pkg::LOW_FLOOR_MS))
			floorMs = 16'(rocof_pkg::LOW_FLOOR_MS); // R10
	end

	assign tripNow = nextElapsed >= floorMs // R9
		&& nextSum >= target // R8
		&& nextSum > mul16(curPick, nextElapsed); // R4
	assign releaseNow = !above
		&& stableCnt == 16'(rocof_pkg::STABLE_MS - 1); // R6

	always_comb begin
		next_state = state;
		if (tick)
			case (state)
				ST_IDLE: if (above) next_state = ST_QUAL;
				ST_QUAL:
					if (!above)
						next_state = ST_IDLE;
					else if (phaseCnt == 16'(rocof_pkg::QUAL_MS - 1))
						next_state = ST_DELAY; // R2
				ST_DELAY:
					if (phaseCnt == 16'(rocof_pkg::DELAY_MS - 1))
						next_state = ST_PICKED; // R3
				ST_PICKED:
					if (tripNow)
						next_state = ST_TRIPPED; // R4
					else if (releaseNow)
						next_state = ST_IDLE; // R6
				ST_TRIPPED: if (releaseNow) next_state = ST_IDLE;
				default: next_state = ST_IDLE;
			endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
			phaseCnt <= 16'h0000;
		end else begin
			state <= next_state;
			if (tick)
				phaseCnt <= (next_state != state) ? 16'h0000
					: phaseCnt + 16'h0001;
			if (tick && state == ST_IDLE)
				phaseCnt <= 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			elapsed <= 16'h0000;
			sum <= 32'h0000_0000;
			maxSlope <= 16'h0000;
			stableCnt <= 16'h0000;
		end else if (tick) begin
			if (state == ST_DELAY) begin
				elapsed <= 16'h0000;
				sum <= 32'h0000_0000;
				maxSlope <= 16'h0000;
				stableCnt <= 16'h0000;
			end else begin
				stableCnt <= above ? 16'h0000 : stableCnt + 16'h0001; // R5
				if (state == ST_PICKED) begin
					elapsed <= nextElapsed;
					sum <= nextSum; // R5
				end
				if (absSlope > maxSlope)
					maxSlope <= absSlope; // R13
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs, events and counters
	// ----------------------------------------------------------------
	logic next_start;
	logic next_trip;
	logic startClr;
	logic tripClr;
	logic [31:0] startCount;
	logic [31:0] tripCount;
	logic [3:0]  evtNow;

	assign next_start = next_state == ST_PICKED || next_state == ST_TRIPPED;
	assign next_trip = next_state == ST_TRIPPED;
	assign startClr = wr && addr == rocof_pkg::OFS_START_COUNT;
	assign tripClr = wr && addr == rocof_pkg::OFS_TRIP_COUNT;
	assign evtNow = evtEn & {!next_trip & tripOut, next_trip & !tripOut,
		!next_start & startOut, next_start & !startOut}; // R14

	always_ff @(posedge clk) begin
		if (!nrst) begin
			startOut <= 1'b0;
			tripOut <= 1'b0;
			startRiseEvt <= 1'b0;
			startFallEvt <= 1'b0;
			tripRiseEvt <= 1'b0;
			tripFallEvt <= 1'b0;
		end else begin
			startOut <= next_start; // R3
			tripOut <= next_trip; // R4
			startRiseEvt <= evtNow[rocof_pkg::EV_START_RISE]; // R14
			startFallEvt <= evtNow[rocof_pkg::EV_START_FALL]; // R14
			tripRiseEvt <= evtNow[rocof_pkg::EV_TRIP_RISE]; // R14
			tripFallEvt <= evtNow[rocof_pkg::EV_TRIP_FALL]; // R14
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			startCount <= 32'h0000_0000;
			tripCount <= 32'h0000_0000;
		end else begin
			if (next_start && !startOut)
				startCount <= startClr ? 32'h0000_0001
					: startCount + 32'h0000_0001; // R12
			else if (startClr)
				startCount <= 32'h0000_0000;
			if (next_trip && !tripOut)
				tripCount <= tripClr ? 32'h0000_0001
					: tripCount + 32'h0000_0001; // R12
			else if (tripClr)
				tripCount <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// fault record
	// ----------------------------------------------------------------
	logic             divDone;
	logic [NUM_W-1:0] divQuo;
	logic [15:0]      faultSlope;
	logic [15:0]      elapsedPct;

	rocof_divider #(.NW(NUM_W), .DW(32)) uDiv (
		.clk  (clk),
		.nrst (nrst),
		.go   (tick && state == ST_PICKED),
		.num  (NUM_W'(sum) * NUM_W'(rocof_pkg::FULL_PCT)),
		.den  (target),
		.done (divDone),
		.quo  (divQuo)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			faultSlope <= 16'h0000;
			elapsedPct <= 16'h0000;
		end else if (next_trip && !tripOut) begin
			faultSlope <= (absSlope > maxSlope) ? absSlope : maxSlope;
			elapsedPct <= rocof_pkg::FULL_PCT; // R13
		end else if (state == ST_PICKED && next_state == ST_IDLE) begin
			faultSlope <= maxSlope; // R13
		end else if (divDone && state == ST_PICKED) begin
			elapsedPct <= (divQuo >= NUM_W'(rocof_pkg::FULL_PCT))
				? rocof_pkg::FULL_PCT - 16'h0001 : divQuo[15:0]; // R13
		end
	end

	// ----------------------------------------------------------------
	// interrupt and register read
	// ----------------------------------------------------------------
	logic [3:0] intStat;
	logic [3:0] intMask;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			intStat <= 4'h0;
			intMask <= 4'h0;
			irq <= 1'b0;
		end else begin
			if (wr && addr == rocof_pkg::OFS_INT_STAT)
				intStat <= (intStat & ~wdata[3:0]) | evtNow;
			else
				intStat <= intStat | evtNow;
			if (wr && addr == rocof_pkg::OFS_INT_MASK)
				intMask <= wdata[3:0];
			irq <= |(intStat & intMask);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			rdata <= 32'h0000_0000;
		else if (rd) begin
			rdata <= 32'h0000_0000;
			if (addr[7:6] == rocof_pkg::GRP_SPACE)
				case (addr[3:2])
					rocof_pkg::GF_PICKUP: rdata <= 32'(pickup[addr[5:4]]);
					rocof_pkg::GF_OP_DELAY: rdata <= 32'(opDelay[addr[5:4]]);
					rocof_pkg::GF_MIN_DELAY:
						rdata <= 32'(minimumDelay[addr[5:4]]);
					default: ;
				endcase
			else
				case (addr)
					rocof_pkg::OFS_CTRL:
						rdata <= 32'({evtEn, grpSrc, manualGrp});
					rocof_pkg::OFS_STATUS:
						rdata <= 32'({freqOk, activeGrp, tripOut, startOut});
					rocof_pkg::OFS_INT_STAT: rdata <= 32'(intStat);
					rocof_pkg::OFS_INT_MASK: rdata <= 32'(intMask);
					rocof_pkg::OFS_START_COUNT: rdata <= startCount; // R12
					rocof_pkg::OFS_TRIP_COUNT: rdata <= tripCount; // R12
					rocof_pkg::OFS_FAULT_SLOPE: rdata <= 32'(faultSlope);
					rocof_pkg::OFS_ELAPSED_PCT: rdata <= 32'(elapsedPct);
					rocof_pkg::OFS_MEAS_FREQ: rdata <= 32'(freqVal); // R15
					rocof_pkg::OFS_MEAS_SLOPE: rdata <= 32'(slopeVal); // R15
					default: ;
				endcase
		end else
			rdata <= 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_no_voltage;
		!(voltOkA || voltOkB) |=> absSlope == 16'h0000 && !freqOk;
	endproperty
	a_no_voltage: assert property (p_no_voltage) // R1
		else $error("slope not blocked without voltage");

	// consecutive ticks above pick-up, independent of the phase counter
	logic [7:0] aboveRun;

	always_ff @(posedge clk) begin
		if (!nrst)
			aboveRun <= 8'h00;
		else if (tick)
			aboveRun <= !above ? 8'h00
				: (aboveRun == 8'hff) ? aboveRun : aboveRun + 8'h01;
	end

	property p_qual;
		state == ST_QUAL ##1 state == ST_DELAY
			|-> aboveRun >= 8'(rocof_pkg::QUAL_MS);
	endproperty
	a_qual: assert property (p_qual) // R2
		else $error("qualification too early");

	property p_pickup;
		$rose(startOut) |-> $past(state) == ST_DELAY
			&& $past(phaseCnt) == 16'(rocof_pkg::DELAY_MS - 1);
	endproperty
	a_pickup: assert property (p_pickup) // R3
		else $error("start without pick-up delay");

	property p_trip_avg;
		$rose(tripOut) |->
			$past(nextSum) > mul16($past(curPick), $past(nextElapsed));
	endproperty
	a_trip_avg: assert property (p_trip_avg) // R4
		else $error("trip with average slope below setting");

	property p_hold;
		(state == ST_PICKED || state == ST_TRIPPED) && !above
			&& stableCnt < 16'(rocof_pkg::STABLE_MS - 1)
			|=> startOut;
	endproperty
	a_hold: assert property (p_hold) // R5
		else $error("released on short slope dip");

	property p_release;
		$fell(startOut) |-> !$past(above)
			&& $past(stableCnt) == 16'(rocof_pkg::STABLE_MS - 1);
	endproperty
	a_release: assert property (p_release) // R6
		else $error("release without stable frequency");

	property p_inverse;
		$rose(tripOut) |-> $past(nextSum) >= $past(target);
	endproperty
	a_inverse: assert property (p_inverse) // R8
		else $error("trip before inverse time");

	property p_floor;
		$rose(tripOut) |-> $past(nextElapsed) >= $past(floorMs)
			&& $past(nextElapsed) >= $past(minimumDelay[activeGrp]);
	endproperty
	a_floor: assert property (p_floor) // R9
		else $error("trip before minimum delay");

	property p_low_slope;
		$rose(tripOut) && $past(curPick) < rocof_pkg::LOW_SLOPE_LIMIT
			|-> $past(nextElapsed) >= 16'(rocof_pkg::LOW_FLOOR_MS);
	endproperty
	a_low_slope: assert property (p_low_slope) // R10
		else $error("low slope setting trip too fast");

	property p_group;
		grpSrc == rocof_pkg::ROCOF_SRC_DIGITAL |=> activeGrp == $past(groupDi);
	endproperty
	a_group: assert property (p_group) // R11
		else $error("active group not from digital input");

	property p_count;
		$rose(startOut) && !$past(startClr)
			|-> startCount == $past(startCount) + 32'h0000_0001;
	endproperty
	a_count: assert property (p_count) // R12
		else $error("start counter not advanced");

	property p_pct;
		$rose(tripOut) |-> elapsedPct == rocof_pkg::FULL_PCT;
	endproperty
	a_pct: assert property (p_pct) // R13
		else $error("elapsed delay not full at trip");

	property p_event;
		$rose(startOut) && $past(evtEn[rocof_pkg::EV_START_RISE])
			|-> startRiseEvt ##1 !startRiseEvt;
	endproperty
	a_event: assert property (p_event) // R14
		else $error("start rise event missing");

	property p_event_off;
		$fell(tripOut) && $past(evtEn[rocof_pkg::EV_TRIP_FALL])
			|-> tripFallEvt ##1 !tripFallEvt;
	endproperty
	a_event_off: assert property (p_event_off) // R14
		else $error("trip fall event missing");

	property p_event_gate;
		$rose(startOut) && !$past(evtEn[rocof_pkg::EV_START_RISE])
			|-> !startRiseEvt;
	endproperty
	a_event_gate: assert property (p_event_gate) // R14
		else $error("start rise event while disabled");

endmodule

`default_nettype wire

// *** rtl/rocof_pkg.sv ***
/*
 * constants of the frequency slope protection stage: register map,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz clock and slope values in 0.01 Hz/s steps.
 */
`default_nettype none

package rocof_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int VW = 16;
	localparam int NGRP = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int QUAL_MS = 80;
	localparam int DELAY_MS = 60;
	localparam int STABLE_MS = 80;
	localparam int LOW_FLOOR_MS = 200;
	localparam logic [15:0] LOW_SLOPE_LIMIT = 16'h0046;
	localparam logic [15:0] FULL_PCT = 16'h0064;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_INT_STAT = 8'h08;
	localparam logic [7:0] OFS_INT_MASK = 8'h0c;
	localparam logic [7:0] OFS_START_COUNT = 8'h10;
	localparam logic [7:0] OFS_TRIP_COUNT = 8'h14;
	localparam logic [7:0] OFS_FAULT_SLOPE = 8'h18;
	localparam logic [7:0] OFS_ELAPSED_PCT = 8'h1c;
	localparam logic [7:0] OFS_MEAS_FREQ = 8'h20;
	localparam logic [7:0] OFS_MEAS_SLOPE = 8'h24;
	localparam logic [1:0] GRP_SPACE = 2'h1;
	localparam logic [1:0] GF_PICKUP = 2'h0;
	localparam logic [1:0] GF_OP_DELAY = 2'h1;
	localparam logic [1:0] GF_MIN_DELAY = 2'h2;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_GRP_LSB = 0;
	localparam int CTRL_SRC_LSB = 2;
	localparam int CTRL_EVT_LSB = 4;
	localparam int EV_START_RISE = 0;
	localparam int EV_START_FALL = 1;
	localparam int EV_TRIP_RISE = 2;
	localparam int EV_TRIP_FALL = 3;
	localparam logic [3:0] EVT_EN_RST = 4'hf;
	localparam logic [15:0] PICKUP_RST = 16'h01f4;
	localparam logic [15:0] OP_DELAY_RST = 16'h01f4;
	localparam logic [15:0] MIN_DELAY_RST = 16'h01f4;

	typedef enum logic [1:0] {
		ROCOF_SRC_MANUAL,
		ROCOF_SRC_DIGITAL,
		ROCOF_SRC_VIRTUAL
	} rocof_src_t;

endpackage

`default_nettype wire

// *** rtl/rocof_tick_gen.sv ***
/*
 * millisecond tick generator.
 * assumes a free running clock; tick is a one cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module rocof_tick_gen #(
	parameter int CYCLES = rocof_pkg::TICK_CYCLES
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// tick
	output logic      tick
);

	localparam int CW = $clog2(CYCLES);

	logic [CW-1:0] cnt;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt == CW'(CYCLES - 1));
			if (cnt == CW'(CYCLES - 1))
				cnt <= '0;
			else
				cnt <= cnt + 1'b1;
		end
	end

endmodule

`default_nettype wire

// *** rtl/rocof_divider.sv ***
/*
 * restoring divider, one quotient bit per clock.
 * assumes go is ignored while busy; zero divisor gives all ones only when num fits in DW bits.
 */
`timescale 1ns/1ps
`default_nettype none

module rocof_divider #(
	parameter int NW = 40,
	parameter int DW = 32
)(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          nrst,
	// request
	input  wire logic          go,
	input  wire logic [NW-1:0] num,
	input  wire logic [DW-1:0] den,
	// answer
	output logic               done,
	output logic [NW-1:0]      quo
);

	localparam int CW = $clog2(NW + 1);

	logic [DW:0]   rem;
	logic [CW-1:0] cnt;
	logic          busy;
	logic [DW:0]   shifted;
	logic [DW:0]   trial;

	assign shifted = {rem[DW-1:0], quo[NW-1]};
	assign trial = shifted - {1'b0, den};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rem <= '0;
			quo <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy && go) begin
				quo <= num;
				rem <= '0;
				cnt <= CW'(NW);
				busy <= 1'b1;
			end else if (busy) begin
				if (!trial[DW]) begin
					rem <= trial;
					quo <= {quo[NW-2:0], 1'b1};
				end else begin
					rem <= shifted;
					quo <= {quo[NW-2:0], 1'b0};
				end
				cnt <= cnt - 1'b1;
				if (cnt == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** tb/rocof_front_end.sv ***
/*
 * measurement front end model: two frequency inputs, live flags, slope.
 * assumes commands from the bench; a dead input shows a moving value.
 */
`timescale 1ns/1ps
`default_nettype none

module rocof_front_end (
	// commands
	input  wire logic        clk,
	input  wire logic [15:0] slopeCmd,
	input  wire logic [1:0]  liveCmd,
	// measurement
	output logic [15:0]      freqA,
	output logic [15:0]      freqB,
	output logic             voltOkA,
	output logic             voltOkB,
	output logic [15:0]      slopeIn
);
	logic [15:0] spin = 16'h0000;

	always_ff @(posedge clk) begin
		spin <= spin + 16'h0001;
		voltOkA <= liveCmd[0];
		voltOkB <= liveCmd[1];
		freqA <= liveCmd[0] ? 16'h1388 : spin;
		freqB <= liveCmd[1] ? 16'h1388 : ~spin;
		slopeIn <= slopeCmd;
	end
endmodule

`default_nettype wire

// *** tb/rocof_stage_tb.sv ***
/*
 * self-checking bench of the slope stage, 10-cycle millisecond tick.
 * assumes the front end model and the stage in rtl.
 */
`timescale 1ns/1ps
`default_nettype none

module rocof_stage_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [1:0]  groupDi = 2'h0;
	logic [1:0]  groupVi = 2'h0;
	logic [1:0]  live = 2'h3;
	logic [15:0] slope = 16'h0000;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] freqA, freqB, slopeIn;
	logic        voltOkA, voltOkB, startOut, tripOut, irq;
	logic [31:0] rdata;
	int          mismatches = 0;
	int          checks = 0;
	logic [7:0]  rowAddr [8] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h40,
		8'h74, 8'h78, 8'h3c};
	logic [31:0] rowExp [8] = '{32'hf0, 32'h10, 32'h0, 32'h0, 32'h1f4,
		32'h1f4, 32'h1f4, 32'h0};

	always #5 clk = ~clk;

	rocof_front_end FE (.clk(clk), .slopeCmd(slope), .liveCmd(live),
		.freqA(freqA), .freqB(freqB), .voltOkA(voltOkA),
		.voltOkB(voltOkB), .slopeIn(slopeIn));

	rocof_stage #(.TICK_CYCLES(10)) DUT (.clk(clk), .nrst(nrst),
		.freqA(freqA), .freqB(freqB), .voltOkA(voltOkA),
		.voltOkB(voltOkB), .slopeIn(slopeIn), .groupDi(groupDi),
		.groupVi(groupVi), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .startOut(startOut),
		.tripOut(tripOut), .startRiseEvt(), .startFallEvt(),
		.tripRiseEvt(), .tripFallEvt(), .irq(irq));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, e);
	endtask

	task automatic fault(input logic [15:0] s, input int lo, input int hi);
		int i;
		slope <= s;
		repeat (1300) @(posedge clk);
		#1 check({31'h0, startOut}, 32'h0);
		for (i = 0; i < 300 && startOut !== 1'b1; i++) @(posedge clk);
		#1 check({31'h0, startOut}, 32'h1);
		repeat (lo * 10) @(posedge clk);
		#1 check({31'h0, tripOut}, 32'h0);
		for (i = 0; i < (hi - lo) * 10 && tripOut !== 1'b1; i++)
			@(posedge clk);
		#1 check({31'h0, tripOut}, 32'h1);
		slope <= 16'h0000;
		for (i = 0; i < 1200 && startOut !== 1'b0; i++) @(posedge clk);
		#1 check({30'h0, startOut, tripOut}, 32'h0);
		$display("fault case done slope=%h", s);
	endtask

	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			expect_reg(rowAddr[i], rowExp[i]);
		end
		$display("reset values done");
		wr_reg(8'h40, 32'h64);
		wr_reg(8'h44, 32'h64);
		wr_reg(8'h48, 32'h64);
		fault(16'h0096, 90, 115);
		expect_reg(8'h08, 32'hf);
		check({31'h0, irq}, 32'h0);
		wr_reg(8'h0c, 32'hf);
		repeat (2) @(posedge clk);
		#1 check({31'h0, irq}, 32'h1);
		wr_reg(8'h08, 32'hf);
		expect_reg(8'h08, 32'h0);
		expect_reg(8'h18, 32'h96);
		expect_reg(8'h1c, 32'h64);
		expect_reg(8'h14, 32'h1);
		$display("definite time done");
		wr_reg(8'h50, 32'h64);
		wr_reg(8'h54, 32'h64);
		wr_reg(8'h58, 32'h14);
		groupDi <= 2'h1;
		wr_reg(8'h00, 32'h04);
		expect_reg(8'h04, 32'h14);
		fault(16'h012c, 30, 40);
		fault(16'h03e8, 15, 25);
		slope <= 16'h012c;
		for (int i = 0; i < 1700 && startOut !== 1'b1; i++) @(posedge clk);
		slope <= 16'h0000;
		repeat (100) @(posedge clk);
		slope <= 16'h012c;
		repeat (300) @(posedge clk);
		#1 check({30'h0, startOut, tripOut}, 32'h2);
		for (int i = 0; i < 200 && tripOut !== 1'b1; i++) @(posedge clk);
		#1 check({31'h0, tripOut}, 32'h1);
		slope <= 16'h0000;
		for (int i = 0; i < 1200 && startOut !== 1'b0; i++) @(posedge clk);
		#1 check({30'h0, startOut, tripOut}, 32'h0);
		$display("slope dip case done");
		expect_reg(8'h08, 32'h0);
		check({31'h0, irq}, 32'h0);
		wr_reg(8'h60, 32'h32);
		wr_reg(8'h64, 32'h64);
		wr_reg(8'h68, 32'h14);
		groupVi <= 2'h2;
		wr_reg(8'h00, 32'hf8);
		fault(16'hfc18, 190, 210);
		expect_reg(8'h10, 32'h5);
		expect_reg(8'h14, 32'h5);
		wr_reg(8'h10, 32'h0);
		expect_reg(8'h10, 32'h0);
		slope <= 16'h0022;
		repeat (3) @(posedge clk);
		expect_reg(8'h24, 32'h22);
		live <= 2'h2;
		repeat (3) @(posedge clk);
		expect_reg(8'h20, 32'h1388);
		live <= 2'h0;
		repeat (3) @(posedge clk);
		expect_reg(8'h04, 32'h08);
		wr_reg(8'h00, 32'h03);
		expect_reg(8'h04, 32'h0c);
		$display("groups and counters done");
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		expect_reg(8'h00, 32'hf0);
		expect_reg(8'h14, 32'h0);
		expect_reg(8'h60, 32'h1f4);
		$display("mid-run reset done");
		wrap_up();
	end
endmodule

`default_nettype wire
